// ---- rtl/cfgsr_top.sv ----
// apb-controlled configurable shift register with parallel load
`timescale 1ns/1ps
`default_nettype none
`include "cfgsr_params.svh"

module cfgsr_top #(
    parameter int register_width = `CFGSR_WIDTH,
    parameter logic [31:0] power_on_value = `CFGSR_POWER_ON,
    parameter logic [31:0] async_preset_value = `CFGSR_ASYNC_PRE,
    parameter logic [31:0] async_clear_value = `CFGSR_ASYNC_CLR,
    parameter logic set_reset_level = `CFGSR_SR_LEVEL
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic shift_clk,
    input wire logic load_sel,
    input wire logic serial_in,
    input wire logic [register_width-1:0] parallel_in,
    input wire logic sync_preset,
    input wire logic sync_clear,
    input wire logic async_preset,
    input wire logic async_clear,
    output logic [register_width-1:0] data_out
);

    localparam int W = register_width;
    localparam int SW = W + 5;

    // ----------------------------------------------------------------
    // input synchronisers
    // ----------------------------------------------------------------
    logic [SW-1:0] pins_raw;
    logic [SW-1:0] pins_m;
    logic [SW-1:0] pins_s;
    logic clk_d;

    assign pins_raw = {shift_clk, load_sel, serial_in, sync_preset, sync_clear, parallel_in};

    // two flops per pin, then one more for the clock edge detector
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pins_m <= '0;
            pins_s <= '0;
            clk_d <= 1'b0;
        end else begin
            pins_m <= pins_raw;
            pins_s <= pins_m;
            clk_d <= pins_s[SW-1];
        end
    end

    logic clk_s;
    logic load_s;
    logic ser_s;
    logic spre_s;
    logic sclr_s;
    logic [W-1:0] par_s;

    assign clk_s = pins_s[SW-1];
    assign load_s = pins_s[SW-2];
    assign ser_s = pins_s[SW-3];
    assign spre_s = pins_s[SW-4];
    assign sclr_s = pins_s[SW-5];
    assign par_s = pins_s[W-1:0];

    // ----------------------------------------------------------------
    // apb register file
    // ----------------------------------------------------------------
    logic [31:0] ctrl;
    logic [W-1:0] spre_val;
    logic [W-1:0] sclr_val;
    logic [31:0] next_ctrl;
    logic [W-1:0] next_spre_val;
    logic [W-1:0] next_sclr_val;
    logic [31:0] next_prdata;
    logic next_pslverr;
    logic [W-1:0] state;

    // address decode shared by read and write paths
    function automatic logic addr_hit(input logic [11:0] a);
        addr_hit = (a == `CFGSR_CTRL_OFS) || (a == `CFGSR_SPRE_OFS) || (a == `CFGSR_SCLR_OFS)
            || (a == `CFGSR_STATE_OFS) || (a == `CFGSR_PINS_OFS);
    endfunction : addr_hit

    assign pready = 1'b1;

    // writes on the access edge, read data captured at setup
    always_comb begin
        next_ctrl = ctrl;
        next_spre_val = spre_val;
        next_sclr_val = sclr_val;
        next_prdata = prdata;
        next_pslverr = pslverr;
        if (psel && penable && pwrite) begin
            case (paddr)
                `CFGSR_CTRL_OFS: next_ctrl = pwdata;
                `CFGSR_SPRE_OFS: next_spre_val = pwdata[W-1:0];
                `CFGSR_SCLR_OFS: next_sclr_val = pwdata[W-1:0];
                default: next_ctrl = ctrl;
            endcase
        end
        if (psel && !penable) begin
            next_pslverr = !addr_hit(paddr);
            next_prdata = 32'h0000_0000;
            if (!pwrite) begin
                case (paddr)
                    `CFGSR_CTRL_OFS: next_prdata = {22'h00_0000, ctrl[9:0]};
                    `CFGSR_SPRE_OFS: next_prdata[W-1:0] = spre_val;
                    `CFGSR_SCLR_OFS: next_prdata[W-1:0] = sclr_val;
                    `CFGSR_STATE_OFS: next_prdata[W-1:0] = state;
                    `CFGSR_PINS_OFS: next_prdata[4:0] = {clk_s, load_s, ser_s, spre_s, sclr_s};
                    default: next_prdata = 32'h0000_0000;
                endcase
            end
        end
    end

    // register stage for the register file
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= `CFGSR_CTRL_RST;
            spre_val <= W'(`CFGSR_SPRE_RST);
            sclr_val <= W'(`CFGSR_SCLR_RST);
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            spre_val <= next_spre_val;
            sclr_val <= next_sclr_val;
            prdata <= next_prdata;
            pslverr <= next_pslverr;
        end
    end

    // ----------------------------------------------------------------
    // shift register core
    // ----------------------------------------------------------------
    cfgsr_pkg::cfgsr_mode_t mode_sel;
    logic [4:0] step;
    logic trig_edge;
    logic load_act;
    logic aset_act;
    logic aclr_act;
    logic [W-1:0] next_state;

    assign mode_sel = cfgsr_pkg::cfgsr_mode_t'(ctrl[`CFGSR_MODE_MSB:`CFGSR_MODE_LSB]);
    assign step = ctrl[`CFGSR_STEP_MSB:`CFGSR_STEP_LSB];
    // only the selected shift clock transition triggers
    assign trig_edge = ctrl[`CFGSR_EDGE_BIT] ? (clk_d && !clk_s) : (!clk_d && clk_s);
    assign load_act = (load_s == ctrl[`CFGSR_LOAD_BIT]);
    assign aset_act = (async_preset == set_reset_level);
    assign aclr_act = (async_clear == set_reset_level);
    assign data_out = state;

    // one shift step in the chosen direction
    function automatic logic [W-1:0] shift_once(input cfgsr_pkg::cfgsr_mode_t m, input logic [W-1:0] v,
                                                 input logic s, input logic [4:0] n);
        logic [W-1:0] fill;
        fill = ~({W{1'b1}} << n);
        case (m)
            cfgsr_pkg::CFGSR_LEFT: shift_once = {v[W-2:0], s};
            cfgsr_pkg::CFGSR_RIGHT: shift_once = {s, v[W-1:1]};
            cfgsr_pkg::CFGSR_MULTI: shift_once = (v << n) | ({W{s}} & fill);
            default: shift_once = v;
        endcase
    endfunction : shift_once

    // sync clear wins over sync set, both over load and shift
    always_comb begin
        next_state = state;
        if (trig_edge) begin
            if (sclr_s == set_reset_level) begin
                next_state = sclr_val;
            end else if (spre_s == set_reset_level) begin
                next_state = spre_val;
            end else if (load_act) begin
                next_state = par_s;
            end else begin
                next_state = shift_once(mode_sel, state, ser_s, step);
            end
        end
    end

    // async clear wins over async preset; power-on value at reset
    always_ff @(posedge pclk or negedge presetn or posedge aclr_act or posedge aset_act) begin
        if (!presetn) begin
            state <= power_on_value[W-1:0];
        end else if (aclr_act) begin
            state <= async_clear_value[W-1:0];
        end else if (aset_act) begin
            state <= async_preset_value[W-1:0];
        end else begin
            state <= next_state;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic async_any;
    logic sync_any;
    assign async_any = aset_act || aclr_act;
    assign sync_any = (sclr_s == set_reset_level) || (spre_s == set_reset_level);

    edge_only_a: assert property ((!trig_edge && !async_any) ##1 !async_any |-> $stable(state))
        else $error("state changed without a triggering edge");
    load_level_a: assert property (trig_edge && load_act && !sync_any && !async_any ##1 !async_any
        |-> state == $past(par_s))
        else $error("parallel load not taken");
    shift_level_a: assert property (trig_edge && !load_act && !sync_any && !async_any
        && mode_sel == cfgsr_pkg::CFGSR_LEFT ##1 !async_any
        |-> state == {$past(state[W-2:0]), $past(ser_s)})
        else $error("left shift wrong");
    right_shift_a: assert property (trig_edge && !load_act && !sync_any && !async_any
        && mode_sel == cfgsr_pkg::CFGSR_RIGHT ##1 !async_any
        |-> state == {$past(ser_s), $past(state[W-1:1])})
        else $error("right shift wrong");
    async_clear_a: assert property (aclr_act && $past(aclr_act) |-> state == async_clear_value[W-1:0])
        else $error("async clear value not held");
    async_preset_a: assert property (aset_act && !aclr_act && $past(aset_act) && !$past(aclr_act)
        |-> state == async_preset_value[W-1:0])
        else $error("async preset value not held");
    sync_clear_a: assert property (trig_edge && sclr_s == set_reset_level && !async_any ##1 !async_any
        |-> state == $past(sclr_val))
        else $error("sync clear value not taken");
    sync_preset_a: assert property (trig_edge && sclr_s != set_reset_level && spre_s == set_reset_level
        && !async_any ##1 !async_any |-> state == $past(spre_val))
        else $error("sync preset value not taken");
    power_on_a: assert property ($rose(presetn) && !async_any |-> state == power_on_value[W-1:0])
        else $error("power-on value missing");

    load_seen_c: cover property (trig_edge && load_act && !sync_any);
    shift_multi_c: cover property (trig_edge && !load_act && mode_sel == cfgsr_pkg::CFGSR_MULTI);
    falling_edge_c: cover property (trig_edge && ctrl[`CFGSR_EDGE_BIT]);
    async_clear_c: cover property (aclr_act);

endmodule : cfgsr_top

`default_nettype wire

// ---- rtl/cfgsr_params.svh ----
// constants for the configurable shift register
`ifndef CFGSR_PARAMS_SVH
`define CFGSR_PARAMS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define CFGSR_CTRL_OFS 12'h000
`define CFGSR_SPRE_OFS 12'h004
`define CFGSR_SCLR_OFS 12'h008
`define CFGSR_STATE_OFS 12'h00c
`define CFGSR_PINS_OFS 12'h010

// ----------------------------------------------------------------
// control field positions
// ----------------------------------------------------------------
`define CFGSR_EDGE_BIT 0
`define CFGSR_LOAD_BIT 1
`define CFGSR_MODE_LSB 2
`define CFGSR_MODE_MSB 4
`define CFGSR_STEP_LSB 5
`define CFGSR_STEP_MSB 9

// ----------------------------------------------------------------
// reset and default values
// ----------------------------------------------------------------
`define CFGSR_WIDTH 8
`define CFGSR_CTRL_RST 32'h0000_0026
`define CFGSR_SPRE_RST 32'hffff_ffff
`define CFGSR_SCLR_RST 32'h0000_0000
`define CFGSR_POWER_ON 32'h0000_0000
`define CFGSR_ASYNC_PRE 32'hffff_ffff
`define CFGSR_ASYNC_CLR 32'h0000_0000
`define CFGSR_SR_LEVEL 1'b1

`endif

// ---- rtl/cfgsr_pkg.sv ----
// types for the configurable shift register
package cfgsr_pkg;

    // shift variant, one-hot
    typedef enum logic [2:0] {
        CFGSR_LEFT = 3'b001,
        CFGSR_RIGHT = 3'b010,
        CFGSR_MULTI = 3'b100
    } cfgsr_mode_t;

endpackage : cfgsr_pkg

// ---- verification/cfgsr_pins_model.sv ----
// pin-side driver model for the configurable shift register
`timescale 1ns/1ps
`default_nettype none

module cfgsr_pins_model #(
    parameter int width = 8
) (
    input wire logic pclk,
    output var logic shift_clk,
    output var logic load_sel,
    output var logic serial_in,
    output var logic [width-1:0] parallel_in,
    output var logic sync_preset,
    output var logic sync_clear
);
    // ----------------------------------------------------------------
    // control and data levels, all changed right after a pclk edge
    // ----------------------------------------------------------------
    // idle levels, shift clock low so reset release shows no edge
    initial begin
        shift_clk = 1'b0;
        load_sel = 1'b0;
        serial_in = 1'b0;
        parallel_in = '0;
        sync_preset = 1'b0;
        sync_clear = 1'b0;
    end

    // levels stay put across the following clock transitions
    task automatic set_pins(input logic ld, input logic ser, input logic sp, input logic sc,
                            input logic [width-1:0] par);
        @(posedge pclk);
        load_sel <= ld;
        serial_in <= ser;
        sync_preset <= sp;
        sync_clear <= sc;
        parallel_in <= par;
    endtask : set_pins

    // one clock level, held four cycles: above the two-cycle minimum
    task automatic clk_level(input logic lvl);
        @(posedge pclk);
        shift_clk <= lvl;
        repeat (4) @(posedge pclk);
    endtask : clk_level
endmodule : cfgsr_pins_model
`default_nettype wire

// ---- verification/cfgsr_top_test.sv ----
// self-checking bench for the configurable shift register
`timescale 1ns/1ps
`default_nettype none

module cfgsr_top_test;
    typedef struct {logic [31:0] ctrl; logic ld; logic ser; logic sp; logic sc; logic [7:0] par; logic [7:0] q;}
        cfgsr_row_t;
    localparam logic [7:0] pon = 8'h42;
    localparam logic [7:0] apre = 8'he7;
    localparam logic [7:0] aclr = 8'h18;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic shift_clk, load_sel, serial_in, sync_preset, sync_clear;
    logic [7:0] parallel_in;
    logic async_preset = 1'b0;
    logic async_clear = 1'b0;
    logic [7:0] data_out;
    logic [31:0] rd;
    logic err;
    int n_fail = 0;
    int checked = 0;
    cfgsr_row_t rows [8] = '{
        '{32'h0000_0006, 1'b1, 1'b0, 1'b0, 1'b0, 8'ha5, 8'ha5},
        '{32'h0000_0006, 1'b0, 1'b1, 1'b0, 1'b0, 8'h00, 8'h4b},
        '{32'h0000_000a, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00, 8'h25},
        '{32'h0000_0070, 1'b1, 1'b1, 1'b0, 1'b0, 8'h00, 8'h2f},
        '{32'h0000_0007, 1'b1, 1'b0, 1'b0, 1'b0, 8'h3c, 8'h3c},
        '{32'h0000_0000, 1'b0, 1'b0, 1'b0, 1'b0, 8'h81, 8'h81},
        '{32'h0000_0006, 1'b0, 1'b0, 1'b1, 1'b0, 8'h00, 8'hc3},
        '{32'h0000_0006, 1'b1, 1'b0, 1'b1, 1'b1, 8'h00, 8'h5a}};

    // ----------------------------------------------------------------
    // clock, design and pin model
    // ----------------------------------------------------------------
    always #20 pclk = ~pclk;

    cfgsr_top #(.power_on_value({24'h0, pon}), .async_preset_value({24'h0, apre}),
        .async_clear_value({24'h0, aclr})) cfgsr_top_inst (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .shift_clk(shift_clk), .load_sel(load_sel),
        .serial_in(serial_in), .parallel_in(parallel_in), .sync_preset(sync_preset), .sync_clear(sync_clear),
        .async_preset(async_preset), .async_clear(async_clear), .data_out(data_out));

    cfgsr_pins_model cfgsr_pins_model_inst (.pclk(pclk), .shift_clk(shift_clk),
        .load_sel(load_sel), .serial_in(serial_in), .parallel_in(parallel_in), .sync_preset(sync_preset),
        .sync_clear(sync_clear));

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    // one apb transfer, request held until pready is seen
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic final_report();
        $display("checks %0d failures %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : final_report

    // watchdog far beyond the expected run
    initial begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        final_report();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check({24'h0, data_out}, {24'h0, pon});
        apb(1'b0, 12'h000, 32'h0);
        check(rd, 32'h0000_0026);
        check({31'h0, err}, 32'h0);
        apb(1'b1, 12'h004, 32'h0000_00c3);
        apb(1'b1, 12'h008, 32'h0000_005a);
        // table of loads, shifts and sync values
        foreach (rows[i]) begin
            apb(1'b1, 12'h000, rows[i].ctrl);
            cfgsr_pins_model_inst.set_pins(rows[i].ld, rows[i].ser, rows[i].sp, rows[i].sc, rows[i].par);
            cfgsr_pins_model_inst.clk_level(1'b1);
            cfgsr_pins_model_inst.clk_level(1'b0);
            check({24'h0, data_out}, {24'h0, rows[i].q});
        end
        // falling edge selected: the rising transition must do nothing
        apb(1'b1, 12'h000, 32'h0000_0007);
        cfgsr_pins_model_inst.set_pins(1'b1, 1'b0, 1'b0, 1'b0, 8'h99);
        cfgsr_pins_model_inst.clk_level(1'b1);
        check({24'h0, data_out}, 32'h0000_005a);
        cfgsr_pins_model_inst.clk_level(1'b0);
        check({24'h0, data_out}, 32'h0000_0099);
        apb(1'b0, 12'h00c, 32'h0);
        check(rd, 32'h0000_0099);
        // state register ignores writes
        apb(1'b1, 12'h00c, 32'h0000_0055);
        apb(1'b0, 12'h00c, 32'h0);
        check(rd, 32'h0000_0099);
        // pins register: clock low, load high, serial and sync inputs low
        apb(1'b0, 12'h010, 32'h0);
        check(rd, 32'h0000_0008);
        // unmapped address is refused
        apb(1'b0, 12'h020, 32'h0);
        check({31'h0, err}, 32'h1);
        check(rd, 32'h0);
        // async set, then clear on top of it, no clock needed
        @(posedge pclk);
        async_preset <= 1'b1;
        #5;
        check({24'h0, data_out}, {24'h0, apre});
        @(posedge pclk);
        async_clear <= 1'b1;
        #5;
        check({24'h0, data_out}, {24'h0, aclr});
        @(posedge pclk);
        async_preset <= 1'b0;
        async_clear <= 1'b0;
        repeat (4) @(posedge pclk);
        check({24'h0, data_out}, {24'h0, aclr});
        // reset again in mid-run: power-on value and register defaults come back
        @(posedge pclk);
        presetn <= 1'b0;
        #5;
        check({24'h0, data_out}, {24'h0, pon});
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check({24'h0, data_out}, {24'h0, pon});
        apb(1'b0, 12'h000, 32'h0);
        check(rd, 32'h0000_0026);
        apb(1'b0, 12'h004, 32'h0);
        check(rd, 32'h0000_00ff);
        final_report();
    end
endmodule : cfgsr_top_test
`default_nettype wire
